// *** etr_consts.vh ***
`ifndef ETR_CONSTS_VH
`define ETR_CONSTS_VH
// register byte offsets
`define ETR_REG_CTRL 6'h00
`define ETR_REG_EXPOSE 6'h04
`define ETR_REG_RDDELAY 6'h08
`define ETR_REG_AOI 6'h0c
`define ETR_REG_SWTRIG 6'h10
`define ETR_REG_STATUS 6'h14
`define ETR_REG_TEMP 6'h18
`define ETR_REG_LUT 6'h1c
`define ETR_REG_NVSAVE 6'h20
`define ETR_REG_TEMPLIM 6'h24
// control field positions
`define ETR_CTRL_MODE_HI 1
`define ETR_CTRL_MODE_LO 0
`define ETR_CTRL_LUTEN 2
`define ETR_CTRL_AOIEN 3
// lut write field positions
`define ETR_LUT_ADDR_HI 27
`define ETR_LUT_ADDR_LO 16
// capture modes
`define ETR_MODE_FREE 2'h0
`define ETR_MODE_PULSE 2'h1
`define ETR_MODE_PROG 2'h2
`define ETR_MODE_DOUBLE 2'h3
// reset values
`define ETR_CTRL_RST 4'h0
`define ETR_EXPOSE_RST 32'h0000c350
`define ETR_RDDELAY_RST 32'h00000000
`define ETR_TEMPLIM_RST 12'h3c0
// timing
`define ETR_CLK_NS 20
`define ETR_FIX_DELAY_NS 100
`define ETR_FIX_CYC ((`ETR_FIX_DELAY_NS + `ETR_CLK_NS - 1) / `ETR_CLK_NS)
`define ETR_PIV_DELAY_NS 5000
`define ETR_PIV_CYC (`ETR_PIV_DELAY_NS / `ETR_CLK_NS)
`define ETR_EXP_MAX_S 60
`define ETR_EXP_MAX_CYC 32'd3000000000
`define ETR_LED_HALF_NS 250000000
`define ETR_LED_HALF_CYC (`ETR_LED_HALF_NS / `ETR_CLK_NS)
`endif

// *** etr_control.v ***
// Behaviour
// [RULE_01] durations are whole clock counts
// [RULE_02] temperature read continuously, readable, red led flashes when hot
// [RULE_03] programmable delay from exposure end to transfer; the code counts rdDelay from the transfer to the readout start
// [RULE_04] free run: continuous frames with line and frame valid strobes
// [RULE_05] mode 0: untriggered, programmed exposure
// [RULE_06] mode 1: trigger rise starts, fall ends exposure and starts readout
// [RULE_07] rise during frame valid waits for line valid fall
// [RULE_08] rise outside frame valid: exposure after fixed delay
// [RULE_09] trigger falls only while frame valid is low
// [RULE_10] mode 2: trigger rise starts, count ends exposure
// [RULE_11] exposure count spans up to 60 seconds
// [RULE_12] new exposure applies at next exposure start
// [RULE_13] saved exposure restored from nonvolatile store
// [RULE_14] software trigger acts like hardware trigger; the code ends a mode 1 software exposure by count, not trigger fall
// [RULE_15] lookup table replaces each converter value
// [RULE_16] lookup table on: 8-bit pixels from 12 bits
// [RULE_17] area of interest reads only selected lines
// [RULE_18] every selected line is read in full; no column limit on timing
// [RULE_19] double shot first exposure starts about 5 us after sync rise
// [RULE_20] double shot: after transfer, readout one and exposure two start
// [RULE_21] exposure two ends with readout one; image two transferred, read
// [RULE_22] during image two readout, requests are ignored
// [RULE_23] exposure and delay timers count down once per cycle
// [RULE_24] four modes; a change applies at frame boundary
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "etr_consts.vh"
module etr_control #(
    parameter LINE_PIXELS = 640,
    parameter LINE_TOTAL = 800,
    parameter FRAME_LINES = 480,
    parameter LED_HALF = `ETR_LED_HALF_CYC
) (
    input wire mclk,
    input wire reset,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output reg avsWaitRequest,
    input wire trigger,
    input wire [11:0] sensorPixel,
    input wire [11:0] tempValue,
    input wire nvValid,
    input wire [31:0] nvExposureIn,
    output reg nvSaveStrobe,
    output reg [31:0] nvExposure,
    output reg sensorExpose,
    output reg sensorTransfer,
    output reg [11:0] sensorLine,
    output reg line_valid,
    output reg frame_valid,
    output reg [11:0] pixelOut,
    output reg ledRed
);
    localparam E_IDLE = 4'h0;
    localparam E_SYNC = 4'h1;
    localparam E_FIX = 4'h2;
    localparam E_EXP = 4'h3;
    localparam E_XFER = 4'h4;
    localparam E_RDLY = 4'h5;
    localparam E_EXP2 = 4'h6;
    localparam E_XFER2 = 4'h7;
    localparam E_LOCK = 4'h8;
    localparam [15:0] LPIX = LINE_PIXELS;
    localparam [15:0] LTOT = LINE_TOTAL;
    localparam [11:0] LLAST = FRAME_LINES - 1;
    localparam [31:0] FIXC = `ETR_FIX_CYC;
    localparam [31:0] PIVC = `ETR_PIV_CYC;
    localparam [31:0] LEDH = LED_HALF;

    reg [3:0] ctrl;
    reg [31:0] exposure;
    reg [31:0] rdDelay;
    reg [11:0] aoiFirst;
    reg [11:0] aoiLast;
    reg [11:0] tempLimit;
    reg [11:0] tempReading;
    reg tempHigh;
    reg swTrig;
    reg nvLoad;
    reg lutWe;
    reg [11:0] lutAddr;
    reg [7:0] lutData;
    reg [3:0] state;
    reg [1:0] curMode;
    reg bySw;
    reg [31:0] expCnt;
    reg [31:0] rdCnt;
    reg trigPrev;
    reg readStart;
    reg reading;
    reg readDone;
    reg [11:0] lineCnt;
    reg [11:0] lastLine;
    reg [15:0] pixCnt;
    reg lvPrev;
    reg lvD1;
    reg fvD1;
    reg lutOn;
    reg [11:0] rawD1;
    reg [31:0] ledCnt;
    wire [7:0] lutOut;
    wire [31:0] wmask;
    wire [31:0] wval;
    wire hwRise;
    wire hwFall;
    wire trigRise;
    wire lvInt;
    wire lineFall;
    wire busWr;

    assign wmask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}}, {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
    assign busWr = avsWrite && !avsWaitRequest;
    assign hwRise = trigger && !trigPrev;
    assign hwFall = !trigger && trigPrev;
    assign trigRise = hwRise || swTrig; // [RULE_14]
    assign lvInt = reading && (pixCnt < LPIX); // [RULE_18]
    assign lineFall = lvPrev && !lvInt;

    // byte-lane merge into the addressed register
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // merged word for the current write over the exposure register; the clamp is applied when exposure is stored
    assign wval = merge(exposure, avsWriteData, wmask);

    // bus handshake: waitrequest drops one cycle after a request
    always @(posedge mclk) begin
        if (reset) begin
            avsWaitRequest <= 1'b1;
        end else if (avsWaitRequest) begin
            if (avsRead || avsWrite) begin
                avsWaitRequest <= 1'b0;
            end
        end else begin
            avsWaitRequest <= 1'b1;
        end
    end

    // read data, captured while waitrequest is still high
    always @(posedge mclk) begin
        if (reset) begin
            avsReadData <= 32'h0;
        end else if (avsRead && avsWaitRequest) begin
            if (avsAddress == `ETR_REG_CTRL) begin
                avsReadData <= {28'h0, ctrl};
            end else if (avsAddress == `ETR_REG_EXPOSE) begin
                avsReadData <= exposure;
            end else if (avsAddress == `ETR_REG_RDDELAY) begin
                avsReadData <= rdDelay;
            end else if (avsAddress == `ETR_REG_AOI) begin
                avsReadData <= {4'h0, aoiLast, 4'h0, aoiFirst};
            end else if (avsAddress == `ETR_REG_STATUS) begin
                avsReadData <= {24'h0, tempHigh, reading, curMode, state};
            end else if (avsAddress == `ETR_REG_TEMP) begin
                avsReadData <= {20'h0, tempReading}; // [RULE_02]
            end else if (avsAddress == `ETR_REG_TEMPLIM) begin
                avsReadData <= {20'h0, tempLimit};
            end else begin
                avsReadData <= 32'h0;
            end
        end
    end

    // register writes and nonvolatile restore after reset
    always @(posedge mclk) begin
        if (reset) begin
            ctrl <= `ETR_CTRL_RST;
            exposure <= `ETR_EXPOSE_RST;
            rdDelay <= `ETR_RDDELAY_RST;
            aoiFirst <= 12'h000;
            aoiLast <= LLAST;
            tempLimit <= `ETR_TEMPLIM_RST;
            swTrig <= 1'b0;
            nvLoad <= 1'b1;
            nvSaveStrobe <= 1'b0;
            nvExposure <= 32'h0;
            lutWe <= 1'b0;
            lutAddr <= 12'h000;
            lutData <= 8'h00;
        end else begin
            swTrig <= 1'b0;
            nvSaveStrobe <= 1'b0;
            lutWe <= 1'b0;
            nvLoad <= 1'b0;
            if (nvLoad && nvValid) begin
                exposure <= nvExposureIn; // [RULE_13]
            end else if (busWr) begin
                if (avsAddress == `ETR_REG_CTRL) begin
                    ctrl <= avsByteEnable[0] ? avsWriteData[3:0] : ctrl;
                end else if (avsAddress == `ETR_REG_EXPOSE) begin
                    if (wval > `ETR_EXP_MAX_CYC) begin
                        exposure <= `ETR_EXP_MAX_CYC; // [RULE_11]
                    end else if (wval == 32'h0) begin
                        exposure <= 32'h1; // [RULE_01]
                    end else begin
                        exposure <= wval;
                    end
                end else if (avsAddress == `ETR_REG_RDDELAY) begin
                    rdDelay <= merge(rdDelay, avsWriteData, wmask); // [RULE_03]
                end else if (avsAddress == `ETR_REG_AOI) begin
                    aoiFirst <= avsWriteData[11:0];
                    aoiLast <= avsWriteData[27:16];
                end else if (avsAddress == `ETR_REG_SWTRIG) begin
                    swTrig <= avsWriteData[0];
                end else if (avsAddress == `ETR_REG_LUT) begin
                    lutWe <= 1'b1;
                    lutAddr <= avsWriteData[`ETR_LUT_ADDR_HI:`ETR_LUT_ADDR_LO];
                    lutData <= avsWriteData[7:0];
                end else if (avsAddress == `ETR_REG_NVSAVE) begin
                    nvSaveStrobe <= avsWriteData[0];
                    nvExposure <= exposure;
                end else if (avsAddress == `ETR_REG_TEMPLIM) begin
                    tempLimit <= avsWriteData[11:0];
                end
            end
        end
    end

    // exposure sequencer
    always @(posedge mclk) begin
        if (reset) begin
            state <= E_IDLE;
            curMode <= `ETR_MODE_FREE;
            bySw <= 1'b0;
            expCnt <= 32'h0;
            rdCnt <= 32'h0;
            trigPrev <= 1'b0;
            readStart <= 1'b0;
            sensorExpose <= 1'b0;
            sensorTransfer <= 1'b0;
        end else begin
            trigPrev <= trigger;
            readStart <= 1'b0;
            sensorTransfer <= 1'b0;
            case (state)
                E_IDLE: begin
                    curMode <= ctrl[`ETR_CTRL_MODE_HI:`ETR_CTRL_MODE_LO]; // [RULE_24]
                    bySw <= swTrig && !hwRise;
                    expCnt <= exposure; // [RULE_12]
                    // hold off until the restored exposure has landed
                    if (nvLoad) begin
                        state <= E_IDLE; // [RULE_13]
                    end else if (ctrl[`ETR_CTRL_MODE_HI:`ETR_CTRL_MODE_LO] == `ETR_MODE_FREE) begin
                        sensorExpose <= 1'b1; // [RULE_05]
                        state <= E_EXP;
                    end else if (trigRise) begin
                        if (ctrl[`ETR_CTRL_MODE_HI:`ETR_CTRL_MODE_LO] == `ETR_MODE_DOUBLE) begin
                            rdCnt <= PIVC; // [RULE_19]
                            state <= E_FIX;
                        end else if (reading) begin
                            state <= E_SYNC; // [RULE_07]
                        end else begin
                            rdCnt <= FIXC; // [RULE_08]
                            state <= E_FIX;
                        end
                    end
                end
                E_SYNC: begin
                    if (lineFall) begin
                        sensorExpose <= 1'b1; // [RULE_07]
                        state <= E_EXP;
                    end
                end
                E_FIX: begin
                    if (rdCnt <= 32'h1) begin
                        sensorExpose <= 1'b1;
                        state <= E_EXP;
                    end else begin
                        rdCnt <= rdCnt - 32'h1;
                    end
                end
                E_EXP: begin
                    if (curMode == `ETR_MODE_PULSE && !bySw) begin
                        if (hwFall) begin
                            sensorExpose <= 1'b0; // [RULE_06]
                            state <= E_XFER;
                        end
                    end else if (expCnt <= 32'h1) begin
                        sensorExpose <= 1'b0; // [RULE_10]
                        state <= E_XFER;
                    end else begin
                        expCnt <= expCnt - 32'h1; // [RULE_23]
                    end
                end
                E_XFER: begin
                    // previous frame must finish before charge moves; pulse falls rely on it
                    if (!reading && !readStart) begin
                        sensorTransfer <= 1'b1; // [RULE_09]
                        rdCnt <= rdDelay;
                        state <= E_RDLY;
                    end
                end
                E_RDLY: begin
                    if (rdCnt == 32'h0) begin
                        readStart <= 1'b1; // [RULE_03]
                        if (curMode == `ETR_MODE_DOUBLE) begin
                            sensorExpose <= 1'b1; // [RULE_20]
                            state <= E_EXP2;
                        end else begin
                            state <= E_IDLE; // [RULE_04]
                        end
                    end else begin
                        rdCnt <= rdCnt - 32'h1; // [RULE_23]
                    end
                end
                E_EXP2: begin
                    if (readDone) begin
                        sensorExpose <= 1'b0; // [RULE_21]
                        state <= E_XFER2;
                    end
                end
                E_XFER2: begin
                    sensorTransfer <= 1'b1; // [RULE_21]
                    readStart <= 1'b1;
                    state <= E_LOCK;
                end
                E_LOCK: begin
                    if (readDone) begin
                        state <= E_IDLE; // [RULE_22]
                    end
                end
                default: begin
                    state <= E_IDLE;
                end
            endcase
        end
    end

    // frame readout counters over the selected lines
    always @(posedge mclk) begin
        if (reset) begin
            reading <= 1'b0;
            readDone <= 1'b0;
            lineCnt <= 12'h000;
            lastLine <= 12'h000;
            pixCnt <= 16'h0000;
            lvPrev <= 1'b0;
            lutOn <= 1'b0;
        end else begin
            readDone <= 1'b0;
            lvPrev <= lvInt;
            if (readStart) begin
                reading <= 1'b1;
                pixCnt <= 16'h0000;
                lutOn <= ctrl[`ETR_CTRL_LUTEN];
                lineCnt <= ctrl[`ETR_CTRL_AOIEN] ? aoiFirst : 12'h000; // [RULE_17]
                lastLine <= ctrl[`ETR_CTRL_AOIEN] ? aoiLast : LLAST;
            end else if (reading) begin
                if (pixCnt == LTOT - 16'h0001) begin
                    pixCnt <= 16'h0000; // [RULE_18]
                    if (lineCnt >= lastLine) begin
                        reading <= 1'b0;
                        readDone <= 1'b1;
                    end else begin
                        lineCnt <= lineCnt + 12'h001;
                    end
                end else begin
                    pixCnt <= pixCnt + 16'h0001;
                end
            end
        end
    end

    etr_lut_mem #(
        .AW(12),
        .DW(8)
    ) lutMem (
        .mclk(mclk),
        .wrEn(lutWe),
        .wrAddr(lutAddr),
        .wrData(lutData),
        .rdAddr(sensorPixel),
        .rdData(lutOut)
    );

    // pixel pipeline aligned with the lut read latency
    always @(posedge mclk) begin
        if (reset) begin
            lvD1 <= 1'b0;
            fvD1 <= 1'b0;
            rawD1 <= 12'h000;
            line_valid <= 1'b0;
            frame_valid <= 1'b0;
            pixelOut <= 12'h000;
            sensorLine <= 12'h000;
        end else begin
            lvD1 <= lvInt;
            fvD1 <= reading;
            rawD1 <= sensorPixel;
            line_valid <= lvD1; // [RULE_04]
            frame_valid <= fvD1;
            sensorLine <= lineCnt;
            if (lutOn) begin
                pixelOut <= {4'h0, lutOut}; // [RULE_15] [RULE_16]
            end else begin
                pixelOut <= rawD1;
            end
        end
    end

    // temperature monitor and red led flash divider
    always @(posedge mclk) begin
        if (reset) begin
            tempReading <= 12'h000;
            tempHigh <= 1'b0;
            ledCnt <= 32'h0;
            ledRed <= 1'b0;
        end else begin
            tempReading <= tempValue;
            tempHigh <= tempReading >= tempLimit; // [RULE_02]
            if (!tempHigh) begin
                ledCnt <= 32'h0;
                ledRed <= 1'b0;
            end else if (ledCnt >= LEDH - 32'h1) begin
                ledCnt <= 32'h0;
                ledRed <= !ledRed; // [RULE_02]
            end else begin
                ledCnt <= ledCnt + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** etr_control_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module etr_control_chk #(
    parameter LINE_PIXELS = 640,
    parameter LINE_TOTAL = 800
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic sensorExpose,
    input wire logic sensorTransfer,
    input wire logic line_valid,
    input wire logic frame_valid,
    input wire logic nvSaveStrobe
);
    logic [31:0] lvRun;
    logic [31:0] fvRun;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // run lengths of the valid strobes
    always @(posedge mclk) begin
        lvRun <= (line_valid && !reset) ? lvRun + 32'h1 : 32'h0;
        fvRun <= (frame_valid && !reset) ? fvRun + 32'h1 : 32'h0;
    end
    // bus answers after exactly one wait cycle
    req_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("access not answered");
    wait_single_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("wait low too long");
    // sensor charge transfer
    xfer_pulse_a: assert property (sensorTransfer |=> !sensorTransfer)
        else $error("transfer too long");
    xfer_follows_a: assert property ($fell(sensorExpose) |-> ##[1:1000] sensorTransfer)
        else $error("no transfer after exposure");
    // output strobes
    line_in_frame_a: assert property (line_valid |-> frame_valid)
        else $error("line outside frame");
    line_len_a: assert property ($fell(line_valid) |-> lvRun == LINE_PIXELS)
        else $error("line length wrong");
    frame_len_a: assert property ($fell(frame_valid) |-> fvRun % LINE_TOTAL == 0)
        else $error("frame not whole lines");
    frame_start_a: assert property ($rose(frame_valid) |-> line_valid)
        else $error("frame starts without line");
    save_pulse_a: assert property (nvSaveStrobe |=> !nvSaveStrobe)
        else $error("save strobe too long");
    cover property ($fell(frame_valid));
    cover property ($rose(sensorTransfer));
    cover property (nvSaveStrobe);
endmodule
bind etr_control etr_control_chk #(.LINE_PIXELS(LINE_PIXELS), .LINE_TOTAL(LINE_TOTAL)) uChk (.*);
`default_nettype wire

// *** etr_control_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "etr_consts.vh"
module etr_control_bench;
    localparam int LP = 8;
    localparam int LT = 12;
    localparam int FL = 4;
    logic mclk, reset, avsRead, avsWrite, nvValid, fire, pixChk, ledOld;
    logic avsWaitRequest, trigger, nvSaveStrobe, sensorExpose, sensorTransfer, line_valid, frame_valid, ledRed;
    logic [5:0] avsAddress;
    logic [11:0] tempValue, sensorPixel, sensorLine, pixelOut, pixBase, expPix;
    logic [15:0] width;
    logic [31:0] avsWriteData, avsReadData, nvExposureIn, nvExposure, nvSeen, q;
    integer n_errors, cmp_count, cyc, tER, tEF, tX, tFR, tFF, tTR, tTF, fvRun, lvRun, fvLast, lvLast, nF, nX, g0, b, k;

    etr_control #(.LINE_PIXELS(LP), .LINE_TOTAL(LT), .FRAME_LINES(FL), .LED_HALF(8)) dut (.*, .avsByteEnable(4'hf));
    etr_far_side far (.*);

    // system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task complete_run;
        begin
            $display("errors %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        begin
            cmp_count++;
            if (seen !== exp) begin
                n_errors++;
                $display("mismatch %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // one bus access held until wait request drops
    task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        integer t;
        begin
            @(posedge mclk);
            avsAddress <= a;
            avsWriteData <= d;
            avsWrite <= w;
            avsRead <= !w;
            t = 0;
            do begin
                @(posedge mclk);
                t++;
            end while (avsWaitRequest !== 1'b0 && t < 20);
            if (t >= 20) begin
                n_errors++;
                complete_run();
            end
            q = avsReadData;
            avsWrite <= 1'b0;
            avsRead <= 1'b0;
        end
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task rc(input logic [5:0] a, input logic [31:0] e, input string nm);
        begin
            acc(1'b0, a, 32'h0);
            chk(q, e, nm);
        end
    endtask

    task trig(input logic [15:0] w);
        begin
            @(posedge mclk);
            fire <= 1'b1;
            width <= w;
            @(posedge mclk);
            fire <= 1'b0;
        end
    endtask

    // wait for n more frame ends (sel 0) or transfers (sel 1)
    task wnf(input logic sel, input integer n);
        integer t, e;
        begin
            t = 0;
            e = (sel ? nX : nF) + n;
            while ((sel ? nX : nF) < e && t < 3000) begin
                @(posedge mclk);
                t++;
            end
            if (t >= 3000) begin
                n_errors++;
                complete_run();
            end
            @(posedge mclk);
        end
    endtask

    // edge timestamps, frame statistics and pixel watch
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        fvRun <= frame_valid ? fvRun + 1 : 0;
        lvRun <= frame_valid ? lvRun + line_valid : 0;
        if ($rose(sensorExpose)) tER <= cyc;
        if ($fell(sensorExpose)) tEF <= cyc;
        if ($rose(trigger)) tTR <= cyc;
        if ($fell(trigger)) tTF <= cyc;
        if ($rose(frame_valid)) tFR <= cyc;
        if ($rose(sensorTransfer)) begin
            tX <= cyc;
            nX <= nX + 1;
        end
        if ($fell(frame_valid)) begin
            tFF <= cyc;
            fvLast <= fvRun;
            lvLast <= lvRun;
            nF <= nF + 1;
        end
        if (nvSaveStrobe === 1'b1) nvSeen <= nvExposure;
        if (pixChk && line_valid === 1'b1) chk({20'h0, pixelOut}, {20'h0, expPix}, "pixel");
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        cyc = 0;
        nF = 0;
        nX = 0;
        fvRun = 0;
        lvRun = 0;
        reset = 1'b1;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 6'h0;
        avsWriteData = 32'h0;
        nvValid = 1'b1;
        nvExposureIn = 32'd40;
        tempValue = 12'h100;
        fire = 1'b0;
        width = 16'h0;
        pixBase = 12'h0a5;
        expPix = 12'h0a5;
        pixChk = 1'b0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        // reset values, restore and clamping
        rc(`ETR_REG_EXPOSE, 32'd40, "expose");
        rc(`ETR_REG_CTRL, 32'h0, "ctrl");
        wr(`ETR_REG_CTRL, 32'h2);
        wnf(0, 1);
        rc(`ETR_REG_RDDELAY, 32'h0, "rddelay");
        rc(`ETR_REG_AOI, 32'h00030000, "aoi");
        rc(`ETR_REG_TEMPLIM, 32'h3c0, "templim");
        rc(6'h3c, 32'h0, "unmapped");
        wr(`ETR_REG_EXPOSE, 32'h0);
        rc(`ETR_REG_EXPOSE, 32'h1, "expose min");
        wr(`ETR_REG_EXPOSE, 32'hffffffff);
        rc(`ETR_REG_EXPOSE, `ETR_EXP_MAX_CYC, "expose max");
        wr(`ETR_REG_EXPOSE, 32'd20);
        wr(`ETR_REG_NVSAVE, 32'h1);
        repeat (3) @(posedge mclk);
        chk(nvSeen, 32'd20, "saved");
        // temperature at and below the limit
        tempValue <= 12'h3c0;
        rc(`ETR_REG_TEMP, 32'h3c0, "temp");
        acc(1'b0, `ETR_REG_STATUS, 32'h0);
        chk({31'h0, q[7]}, 32'h1, "hot");
        ledOld = ledRed;
        repeat (8) @(posedge mclk);
        chk({31'h0, ledRed ^ ledOld}, 32'h1, "led toggle");
        tempValue <= 12'h3bf;
        repeat (4) @(posedge mclk);
        chk({31'h0, ledRed}, 32'h0, "led cool");
        // programmed exposure, then readout delay
        wr(`ETR_REG_CTRL, 32'h2);
        acc(1'b0, `ETR_REG_STATUS, 32'h0);
        chk({30'h0, q[5:4]}, 32'h2, "mode");
        pixChk = 1'b1;
        trig(16'd3);
        wnf(0, 1);
        chk(tEF - tER, 32'd20, "exposure");
        chk({31'h0, tER - tTR > 2 && tER - tTR < 10}, 32'h1, "fixed delay");
        chk(fvLast, FL * LT, "frame");
        chk(lvLast, FL * LP, "line cycles");
        g0 = tFR - tX;
        wr(`ETR_REG_RDDELAY, 32'd3);
        trig(16'd3);
        wnf(0, 1);
        chk(tFR - tX - g0, 32'd3, "readout delay");
        wr(`ETR_REG_SWTRIG, 32'h1);
        wnf(0, 1);
        chk(tEF - tER, 32'd20, "sw exposure");
        // lookup table, then area of interest with it
        wr(`ETR_REG_LUT, 32'h00a5003c);
        wr(`ETR_REG_CTRL, 32'h6);
        expPix = 12'h03c;
        trig(16'd3);
        wnf(0, 1);
        wr(`ETR_REG_AOI, 32'h00020001);
        wr(`ETR_REG_CTRL, 32'he);
        trig(16'd3);
        wnf(0, 1);
        chk(fvLast, 2 * LT, "aoi frame");
        chk(lvLast, 2 * LP, "aoi lines");
        // pulse width exposure
        wr(`ETR_REG_CTRL, 32'h1);
        expPix = 12'h0a5;
        trig(16'd40);
        wnf(0, 1);
        chk({31'h0, tEF >= tTF && tEF <= tTF + 3}, 32'h1, "pulse end");
        chk(fvLast, FL * LT, "frame full");
        // free run with no trigger
        wr(`ETR_REG_CTRL, 32'h0);
        wnf(0, 2);
        chk(fvLast, FL * LT, "free frame");
        // double shot, with a trigger during the second readout
        wr(`ETR_REG_CTRL, 32'h3);
        wnf(0, 1);
        repeat (300) @(posedge mclk);
        b = nF;
        k = nX;
        trig(16'd3);
        wnf(1, 1);
        chk({31'h0, tER - tTR >= 245 && tER - tTR <= 260}, 32'h1, "shot delay");
        wnf(0, 1);
        chk({31'h0, tFR - tER >= 0 && tFR - tER <= 3}, 32'h1, "second start");
        chk({31'h0, tFF - tEF >= 0 && tFF - tEF <= 4}, 32'h1, "second end");
        repeat (20) @(posedge mclk);
        trig(16'd3);
        wnf(0, 1);
        repeat (400) @(posedge mclk);
        chk(nX - k, 32'd2, "transfers");
        chk(nF - b, 32'd2, "ignored");
        complete_run();
    end
endmodule
`default_nettype wire

// *** etr_far_side.sv ***
`timescale 1ns/10ps
`default_nettype none
module etr_far_side (
    input wire logic mclk,
    input wire logic reset,
    input wire logic fire,
    input wire logic [15:0] width,
    input wire logic [11:0] pixBase,
    input wire logic frame_valid,
    output logic trigger,
    output wire logic [11:0] sensorPixel
);
    logic [15:0] hold;
    // trigger pulse; its fall waits until readout has ended
    always @(posedge mclk) begin
        if (reset) begin
            trigger <= 1'b0;
            hold <= 16'h0;
        end else if (fire) begin
            trigger <= 1'b1;
            hold <= width;
        end else if (hold != 16'h0) begin
            hold <= hold - 16'h1;
        end else if (!frame_valid) begin
            trigger <= 1'b0;
        end
    end
    // converter value held steady per frame
    assign sensorPixel = pixBase;
endmodule
`default_nettype wire

// *** etr_lut_mem.v ***
`timescale 1ns/10ps
`default_nettype none
module etr_lut_mem #(
    parameter AW = 12,
    parameter DW = 8
) (
    input wire mclk,
    input wire wrEn,
    input wire [AW-1:0] wrAddr,
    input wire [DW-1:0] wrData,
    input wire [AW-1:0] rdAddr,
    output reg [DW-1:0] rdData
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // write port and registered read port
    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire
